// ==== src/hcu_cmd_unit.sv ====
`timescale 1ns/1ps
`include "hcu_consts.svh"
module hcu_cmd_unit (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_cmd_valid,
  input  wire hcu_pkg::hcu_cmd_t     i_cmd,
  input  wire logic [511:0]          i_msg,
  output logic                       o_cmd_ready,
  output logic [3:0]                 o_slot_sel,
  input  wire hcu_pkg::hcu_slot_t    i_slot,
  input  wire logic                  i_data_locked,
  input  wire logic [71:0]           i_serial,
  input  wire logic                  i_tk_load,
  input  wire hcu_pkg::hcu_tk_t      i_tk_new,
  output hcu_pkg::hcu_sha_req_t      o_sha,
  input  wire logic                  i_sha_done,
  input  wire logic                  i_sha_err,
  input  wire logic [255:0]          i_sha_digest,
  output hcu_pkg::hcu_ecc_req_t      o_ecc,
  input  wire logic                  i_ecc_done,
  input  wire logic                  i_ecc_fault,
  input  wire logic [511:0]          i_ecc_sig,
  output hcu_pkg::hcu_rsp_t          o_rsp,
  output hcu_pkg::hcu_tk_t           o_tk,
  output logic                       o_ctx_valid
);

  // ==========================================================
  // Helpers

  // One-byte answer; a nonzero code is an error and wipes both the
  // hash context and the temporary digest register
  function automatic hcu_pkg::hcu_regs_t put_status(
    input hcu_pkg::hcu_regs_t s,
    input logic [7:0]         code
  );
    hcu_pkg::hcu_regs_t t;
    t              = s;
    t.rsp.valid    = 1'b1;
    t.rsp.len      = `HCU_STATUS_BYTES;
    t.rsp.data     = {code, 504'h0};
    t.st           = hcu_pkg::HCU_IDLE;
    if (code != `HCU_STATUS_OK) begin
      t.ctx_valid  = 1'b0;
      t.ctx_keyed  = 1'b0;
      t.tk.valid   = 1'b0;
    end
    return t;
  endfunction

  // Slot a hash command refers to: key slot for keyed start,
  // public-key slot for public mode, low bits of the second parameter otherwise
  function automatic logic [3:0] hash_slot(input hcu_pkg::hcu_cmd_t c);
    return c.second_parameter[3:0];
  endfunction

  // Parameter check of a hash command against the addressed slot
  function automatic logic [7:0] hash_check(
    input hcu_pkg::hcu_cmd_t  c,
    input hcu_pkg::hcu_slot_t sl,
    input logic               ctx_ok,
    input logic               keyed
  );
    logic [7:0] code;
    code = `HCU_STATUS_OK;
    if ((c.mode & `HCU_HASH_RSVD_MASK) != 8'h00 ||
        c.mode[2:0] > `HCU_HMODE_KEND) begin
      code = `HCU_ERR_PARAM;
    end else begin
      case (c.mode[2:0])
        `HCU_HMODE_START: begin
          if (c.second_parameter != 16'h0000) code = `HCU_ERR_PARAM;
        end
        `HCU_HMODE_UPDATE: begin
          if (c.second_parameter != `HCU_BLOCK_BYTES) code = `HCU_ERR_PARAM;
          else if (!ctx_ok) code = `HCU_ERR_EXEC;
        end
        `HCU_HMODE_END, `HCU_HMODE_KEND: begin
          if (c.second_parameter > `HCU_FINAL_MAX) code = `HCU_ERR_PARAM;
          else if (!ctx_ok) code = `HCU_ERR_EXEC;
          else if (keyed != (c.mode[2:0] == `HCU_HMODE_KEND)) begin
            code = `HCU_ERR_EXEC;
          end
        end
        // slot must hold a public key
        `HCU_HMODE_PUBLIC: begin
          if (c.second_parameter > `HCU_SLOT_MAX) code = `HCU_ERR_PARAM;
          else if (!ctx_ok || !sl.is_pubkey) code = `HCU_ERR_EXEC;
        end
        `HCU_HMODE_KSTART: begin
          if (c.second_parameter > `HCU_SLOT_MAX) code = `HCU_ERR_PARAM;
        end
        default: code = `HCU_ERR_PARAM;
      endcase
    end
    return code;
  endfunction

  // Gatekeeping of a signing command against slot and digest state
  function automatic logic [7:0] sign_check(
    input hcu_pkg::hcu_cmd_t  c,
    input hcu_pkg::hcu_slot_t sl,
    input hcu_pkg::hcu_tk_t   tk,
    input logic               zone_locked
  );
    logic [7:0] code;
    code = `HCU_STATUS_OK;
    if ((c.mode & `HCU_SIGN_RSVD_MASK) != 8'h00 ||
        c.second_parameter > `HCU_SLOT_MAX) begin
      code = `HCU_ERR_PARAM;
    end else if (!sl.key_cfg[`HCU_KEY_PRIV_BIT] ||
                 !sl.slot_cfg[`HCU_SECRET_BIT]) begin
      code = `HCU_ERR_EXEC;
    end else if (c.mode[`HCU_SIGN_EXT_BIT]) begin
      if (!sl.slot_cfg[`HCU_PERM_EXT_BIT]) code = `HCU_ERR_EXEC;
      else if (!tk.valid) code = `HCU_ERR_EXEC;
    end else begin
      if (!zone_locked) code = `HCU_ERR_EXEC;
      else if (!sl.slot_cfg[`HCU_PERM_INT_BIT]) code = `HCU_ERR_EXEC;
      else if (!tk.valid || !(tk.gen_dig || tk.gen_key)) begin
        code = `HCU_ERR_EXEC;
      end
    end
    return code;
  endfunction

  // ==========================================================
  // State

  hcu_pkg::hcu_regs_t r_r;
  hcu_pkg::hcu_regs_t r_nxt;

  logic [7:0]   code_w;
  logic [439:0] smsg_w;
  logic [31:0]  sn_mid_w;
  logic [15:0]  sn_hi_w;

  // Serial fields that the mode bit may blank out
  // serial bits optional
  assign sn_mid_w = r_r.cmd.mode[`HCU_SIGN_SN_BIT] ? i_serial[39:8]
                                                  : 32'h0;
  assign sn_hi_w  = r_r.cmd.mode[`HCU_SIGN_SN_BIT] ? i_serial[55:40]
                                                  : 16'h0;

  // Internal signing message, first byte in the top bits
  // digest plus device state
  assign smsg_w = {r_r.tk.data, `HCU_OP_SIGN, r_r.cmd.mode,
                   r_r.cmd.second_parameter, i_slot.slot_cfg, i_slot.key_cfg,
                   r_r.tk.nomac, r_r.tk.gen_key, r_r.tk.gen_dig,
                   r_r.tk.src, r_r.tk.keyid, 16'h0000,
                   i_serial[7:0], sn_mid_w, i_serial[71:56], sn_hi_w,
                   7'h00, i_slot.locked, 7'h00, i_slot.pubkey_valid,
                   8'h00};

  // Next-state logic; request and answer strobes last one cycle
  always_comb begin
    r_nxt         = r_r;
    code_w        = `HCU_STATUS_OK;
    r_nxt.sha.req = 1'b0;
    r_nxt.ecc.req = 1'b0;
    r_nxt.rsp.valid = 1'b0;
    // Digest written by other commands; later writes below win
    if (i_tk_load) begin
      r_nxt.tk = i_tk_new;
    end
    case (r_r.st)
      hcu_pkg::HCU_IDLE: begin
        if (i_cmd_valid) begin
          r_nxt.cmd      = i_cmd;
          r_nxt.sha.data = i_msg;
          r_nxt.slot_sel = hash_slot(i_cmd);
          if (i_cmd.opcode == `HCU_OP_HASH) begin
            r_nxt.st = hcu_pkg::HCU_CHECK;
          end else if (i_cmd.opcode == `HCU_OP_SIGN) begin
            r_nxt.ctx_valid = 1'b0;
            r_nxt.ctx_keyed = 1'b0;
            r_nxt.slot_sel  = i_cmd.second_parameter[3:0];
            r_nxt.st        = hcu_pkg::HCU_CHECK;
          end else begin
            r_nxt.ctx_valid = 1'b0;
            r_nxt.ctx_keyed = 1'b0;
            if (!i_tk_load) r_nxt.tk.valid = 1'b0;
          end
        end
      end
      hcu_pkg::HCU_CHECK: begin
        // Slot data follows the registered select within the cycle
        if (r_r.cmd.opcode == `HCU_OP_HASH) begin
          code_w = hash_check(r_r.cmd, i_slot, r_r.ctx_valid,
                              r_r.ctx_keyed);
          if (code_w != `HCU_STATUS_OK) begin
            r_nxt = put_status(r_nxt, code_w);
          end else begin
            r_nxt.sha.req  = 1'b1;
            r_nxt.sha.op   = r_r.cmd.mode[2:0];
            r_nxt.sha.slot = r_r.slot_sel;
            r_nxt.sha.len  = r_r.cmd.mode[2:0] == `HCU_HMODE_UPDATE ||
                             r_r.cmd.mode[2:0] == `HCU_HMODE_END ||
                             r_r.cmd.mode[2:0] == `HCU_HMODE_KEND
                             ? r_r.cmd.second_parameter[6:0] : 7'h00;
            r_nxt.st       = hcu_pkg::HCU_HASH;
          end
        end else begin
          code_w = sign_check(r_r.cmd, i_slot, r_r.tk, i_data_locked);
          if (code_w != `HCU_STATUS_OK) begin
            r_nxt = put_status(r_nxt, code_w);
          end else if (r_r.cmd.mode[`HCU_SIGN_EXT_BIT]) begin
            r_nxt.ecc.req    = 1'b1;
            r_nxt.ecc.slot   = r_r.slot_sel;
            r_nxt.ecc.digest = r_r.tk.data;
            r_nxt.st         = hcu_pkg::HCU_ECC;
          end else begin
            // Look up settings of the key behind the digest
            r_nxt.slot_sel = r_r.tk.keyid;
            r_nxt.st       = hcu_pkg::HCU_TKLOOK;
          end
        end
      end
      hcu_pkg::HCU_TKLOOK: begin
        r_nxt.sha.req  = 1'b1;
        r_nxt.sha.op   = `HCU_HMODE_ONESHOT;
        r_nxt.sha.slot = r_r.tk.keyid;
        r_nxt.sha.len  = `HCU_SIGN_MSG_BYTES;
        r_nxt.sha.data = {smsg_w, 72'h0};
        r_nxt.slot_sel = r_r.cmd.second_parameter[3:0];
        r_nxt.st       = hcu_pkg::HCU_HASH;
      end
      hcu_pkg::HCU_HASH: begin
        if (i_sha_done) begin
          if (i_sha_err) begin
            r_nxt = put_status(r_nxt, `HCU_ERR_EXEC);
          end else if (r_r.cmd.opcode == `HCU_OP_SIGN) begin
            r_nxt.ecc.req    = 1'b1;
            r_nxt.ecc.slot   = r_r.cmd.second_parameter[3:0];
            r_nxt.ecc.digest = i_sha_digest;
            r_nxt.st         = hcu_pkg::HCU_ECC;
          end else begin
            case (r_r.cmd.mode[2:0])
              `HCU_HMODE_START, `HCU_HMODE_KSTART: begin
                r_nxt.tk        = '0;
                r_nxt.tk.data   = i_sha_digest;
                r_nxt.ctx_valid = 1'b1;
                r_nxt.ctx_keyed = r_r.cmd.mode[2];
                r_nxt = put_status(r_nxt, `HCU_STATUS_OK);
              end
              `HCU_HMODE_END, `HCU_HMODE_KEND: begin
                r_nxt.tk        = '0;
                r_nxt.tk.data   = i_sha_digest;
                r_nxt.tk.valid  = 1'b1;
                r_nxt.ctx_valid = 1'b0;
                r_nxt.ctx_keyed = 1'b0;
                r_nxt.rsp.valid = 1'b1;
                r_nxt.rsp.len   = `HCU_DIGEST_BYTES;
                r_nxt.rsp.data  = {i_sha_digest, 256'h0};
                r_nxt.st        = hcu_pkg::HCU_IDLE;
              end
              default: begin
                r_nxt = put_status(r_nxt, `HCU_STATUS_OK);
              end
            endcase
          end
        end
      end
      hcu_pkg::HCU_ECC: begin
        if (i_ecc_done) begin
          if (i_ecc_fault) begin
            r_nxt = put_status(r_nxt, `HCU_ERR_ECC);
          end else begin
            r_nxt.rsp.valid = 1'b1;
            r_nxt.rsp.len   = `HCU_SIG_BYTES;
            r_nxt.rsp.data  = i_ecc_sig;
            r_nxt.tk.valid  = 1'b0;
            r_nxt.st        = hcu_pkg::HCU_IDLE;
          end
        end
      end
      default: begin
        r_nxt.st = hcu_pkg::HCU_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign o_cmd_ready = (r_r.st == hcu_pkg::HCU_IDLE);
  assign o_slot_sel  = r_r.slot_sel;
  assign o_sha       = r_r.sha;
  assign o_ecc       = r_r.ecc;
  assign o_rsp       = r_r.rsp;
  assign o_tk        = r_r.tk;
  assign o_ctx_valid = r_r.ctx_valid;

endmodule

// ==== src/hcu_consts.svh ====
`ifndef HCU_CONSTS_SVH
`define HCU_CONSTS_SVH

// ==========================================================
// Opcodes
`define HCU_OP_HASH          8'h47
`define HCU_OP_SIGN          8'h41

// ==========================================================
// Hash modes, also the operation codes of the hash engine
`define HCU_HMODE_START      3'h0
`define HCU_HMODE_UPDATE     3'h1
`define HCU_HMODE_END        3'h2
`define HCU_HMODE_PUBLIC     3'h3
`define HCU_HMODE_KSTART     3'h4
`define HCU_HMODE_KEND       3'h5
`define HCU_HMODE_ONESHOT    3'h6
`define HCU_HASH_RSVD_MASK   8'hf8

// ==========================================================
// Length limits
`define HCU_BLOCK_BYTES      16'h0040
`define HCU_FINAL_MAX        16'h003f
`define HCU_SLOT_MAX         16'h000f
`define HCU_SIGN_MSG_BYTES   7'h37
`define HCU_DIGEST_BYTES     7'h20
`define HCU_SIG_BYTES        7'h40
`define HCU_STATUS_BYTES     7'h01

// ==========================================================
// Status and error codes
`define HCU_STATUS_OK        8'h00
`define HCU_ERR_PARAM        8'he1
`define HCU_ERR_EXEC         8'he2
`define HCU_ERR_ECC          8'he3

// ==========================================================
// Signing mode fields
`define HCU_SIGN_EXT_BIT     7
`define HCU_SIGN_SN_BIT      6
`define HCU_SIGN_RSVD_MASK   8'h3e

// ==========================================================
// Slot and key settings word fields
`define HCU_PERM_EXT_BIT     0
`define HCU_PERM_INT_BIT     1
`define HCU_SECRET_BIT       7
`define HCU_KEY_PRIV_BIT     0

`endif

// ==== src/hcu_pkg.sv ====
package hcu_pkg;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    HCU_IDLE   = 3'b000,
    HCU_CHECK  = 3'b001,
    HCU_TKLOOK = 3'b010,
    HCU_HASH   = 3'b011,
    HCU_ECC    = 3'b100
  } hcu_state_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  mode;
    logic [15:0] second_parameter;
  } hcu_cmd_t;

  typedef struct packed {
    logic [15:0] slot_cfg;
    logic [15:0] key_cfg;
    logic        is_pubkey;
    logic        locked;
    logic        pubkey_valid;
  } hcu_slot_t;

  typedef struct packed {
    logic [255:0] data;
    logic         valid;
    logic         nomac;
    logic         gen_key;
    logic         gen_dig;
    logic         src;
    logic [3:0]   keyid;
  } hcu_tk_t;

  typedef struct packed {
    logic         req;
    logic [2:0]   op;
    logic [3:0]   slot;
    logic [6:0]   len;
    logic [511:0] data;
  } hcu_sha_req_t;

  typedef struct packed {
    logic         req;
    logic [3:0]   slot;
    logic [255:0] digest;
  } hcu_ecc_req_t;

  typedef struct packed {
    logic         valid;
    logic [6:0]   len;
    logic [511:0] data;
  } hcu_rsp_t;

  typedef struct packed {
    hcu_state_t   st;
    hcu_cmd_t     cmd;
    hcu_tk_t      tk;
    logic         ctx_valid;
    logic         ctx_keyed;
    logic [3:0]   slot_sel;
    hcu_sha_req_t sha;
    hcu_ecc_req_t ecc;
    hcu_rsp_t     rsp;
  } hcu_regs_t;

endpackage

// ==== tb/hash_and_sign_command_unit_test.sv ====
`timescale 1ns/1ps
`include "hcu_consts.svh"
module hash_and_sign_command_unit_test;
  logic                  clk, rst, cv, tkl, lck, flt, rdy, sdn, edn, efl;
  logic                  ctxv;
  logic [3:0]            sel, lat;
  logic [31:0]           rs;
  logic [71:0]           sn;
  logic [255:0]          sdg;
  logic [511:0]          msg, sig, shd;
  hcu_pkg::hcu_cmd_t     cmd;
  hcu_pkg::hcu_tk_t      tkn, tk;
  hcu_pkg::hcu_slot_t    slot, tab [16];
  hcu_pkg::hcu_sha_req_t sha;
  hcu_pkg::hcu_ecc_req_t ecc;
  hcu_pkg::hcu_rsp_t     rsp;
  int                    errors, n_checks, ctx;
  localparam logic [23:0] HC [25] = '{24'h000001, 24'h010040, 24'h000000,
    24'h01003f, 24'h000000, 24'h010040, 24'h030002, 24'h030003, 24'h000000,
    24'h020040, 24'h000000, 24'h010040, 24'h02003f, 24'h040001, 24'h010040,
    24'h030002, 24'h050000, 24'h040010, 24'h000000, 24'h050005, 24'h080000,
    24'h060000, 24'h070000, 24'h000000, 24'h020000};
  localparam logic [31:0] SC [13] = '{32'ha040_0005, 32'h2800_0005,
    32'h8840_0005, 32'ha840_0007, 32'hac40_0005, 32'ha840_0005,
    32'hc800_0005, 32'h9880_0005, 32'h9880_0006, 32'h9880_0007,
    32'h9880_0008, 32'h9842_0005, 32'h9880_0010};
  hcu_cmd_unit i_dut (.i_core_clk(clk), .i_rst(rst), .i_cmd_valid(cv),
    .i_cmd(cmd), .i_msg(msg), .o_cmd_ready(rdy), .o_slot_sel(sel),
    .i_slot(slot), .i_data_locked(lck), .i_serial(sn), .i_tk_load(tkl),
    .i_tk_new(tkn), .o_sha(sha), .i_sha_done(sdn), .i_sha_err(1'b0),
    .i_sha_digest(sdg), .o_ecc(ecc), .i_ecc_done(edn), .i_ecc_fault(efl),
    .i_ecc_sig(sig), .o_rsp(rsp), .o_tk(tk), .o_ctx_valid(ctxv));
  hcu_far_model i_far (.i_core_clk(clk), .i_rst(rst), .i_slot_sel(sel),
    .i_tab(tab), .i_sha(sha), .i_ecc(ecc), .i_fault(flt), .i_lat(lat),
    .o_slot(slot), .o_sha_done(sdn), .o_sha_dig(sdg), .o_ecc_done(edn),
    .o_ecc_fault(efl), .o_ecc_sig(sig));
  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Keep the data of the last hash engine request for message checks
  always @(posedge clk) begin
    if (sha.req) shd <= sha.data;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic rnd(output logic [511:0] v);
    for (int i = 0; i < 16; i++) begin
      rs = xs(rs);
      v = {v[479:0], rs};
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [511:0] got, input logic [511:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: value mismatch", $time);
    end
  endtask
  task automatic hang;
    errors++;
    $display("CHECK FAILED at %0t: no handshake", $time);
    tally_and_finish;
  endtask
  // Offer one command, hold it until taken, then await its answer when ans is set
  task automatic issue(input logic [7:0] op, md, input logic [15:0] p2,
                       input logic ans);
    logic [511:0] m;
    int           k;
    rnd(m);
    @(posedge clk);
    cv <= 1'b1;
    cmd <= '{op, md, p2};
    msg <= m;
    lat <= rs[3:0];
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    cv <= 1'b0;
    if (k >= 50) hang();
    k = 0;
    while (ans && rsp.valid !== 1'b1 && k < 300) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 300) hang();
  endtask
  // Status byte answer; ff stands for any error code
  task automatic stat(input logic [7:0] e);
    if (e == 8'hff) chk({rsp.len, rsp.data[511:504] != 8'h00}, 8'h03);
    else chk({rsp.len, rsp.data[511:504]}, {7'h01, e});
  endtask
  // Hash command against a context model of the rules
  task automatic hash(input logic [7:0] md, input logic [15:0] p2);
    logic [7:0]   e;
    logic [255:0] d;
    if (md[7:3] != 5'h00 || md[2:0] > 3'h5) e = 8'he1;
    else if (md == 8'h00) e = p2 != 16'h0 ? 8'he1 : 8'h00;
    else if (md == 8'h01) e = p2 != 16'h40 ? 8'he1 : ctx == 0 ? 8'he2 : 0;
    else if (md == 8'h03) e = p2 > 15 ? 8'he1 : ctx == 0 ? 8'he2 :
      tab[p2[3:0]].is_pubkey ? 8'h00 : 8'hff;
    else if (md == 8'h04) e = p2 > 15 ? 8'he1 : 8'h00;
    else e = p2 > 63 ? 8'he1 : ctx != (md[2] ? 2 : 1) ? 8'he2 : 8'h00;
    issue(`HCU_OP_HASH, md, p2, 1'b1);
    d = shd[511:256] ^ shd[255:0];
    if (e == 8'h00 && (md == 8'h02 || md == 8'h05)) begin
      chk(rsp.len, 7'h20);
      chk({rsp.data[511:256], tk.data}, {d, d});
    end else stat(e);
    if (md == 8'h01 && e == 8'h00) chk(shd, msg);
    if (e != 8'h00 || md == 8'h02 || md == 8'h05) ctx = 0;
    else if (md == 8'h00 || md == 8'h04) ctx = md[2] ? 2 : 1;
    chk(ctxv, ctx != 0);
  endtask
  // Load the digest register as another command would
  task automatic ldtk(input logic [3:0] fl);
    logic [511:0] m;
    rnd(m);
    @(posedge clk);
    tkl <= 1'b1;
    tkn <= '{m[255:0], fl[3], 1'b0, fl[2], fl[1], fl[0], 4'h5};
    @(posedge clk);
    tkl <= 1'b0;
  endtask
  // Signing command against the permission rules
  task automatic sign(input logic [7:0] md, input logic [15:0] p2);
    logic               ok;
    logic [255:0]       d;
    hcu_pkg::hcu_slot_t s;
    s = tab[p2[3:0]];
    ok = (md & 8'h3e) == 0 && p2 < 16 && s.key_cfg[0] && s.slot_cfg[7] &&
      tkn.valid && (md[7] ? s.slot_cfg[0] :
      lck && s.slot_cfg[1] && (tkn.gen_key || tkn.gen_dig));
    issue(`HCU_OP_SIGN, md, p2, 1'b1);
    ctx = 0;
    d = md[7] ? tkn.data : shd[511:256] ^ shd[255:0];
    if (!ok) stat(8'hff);
    else if (flt) stat(8'he3);
    else chk({rsp.len, rsp.data}, {7'h40, d, ~d});
    if (ok && !md[7]) chk(shd, {tkn.data, 8'h41, md, p2,
      tab[tkn.keyid].slot_cfg, tab[tkn.keyid].key_cfg, tkn.nomac,
      tkn.gen_key, tkn.gen_dig, tkn.src, tkn.keyid, 16'h0, sn[7:0],
      md[6] ? sn[39:8] : 32'h0, sn[71:56], md[6] ? sn[55:40] : 16'h0,
      7'h0, tab[tkn.keyid].locked, 7'h0, tab[tkn.keyid].pubkey_valid,
      80'h0});
    chk(tk.valid, 1'b0);
  endtask
  // Main sequence
  initial begin
    logic [511:0] m;
    rs = 32'hf21f;
    errors = 0;
    n_checks = 0;
    ctx = 0;
    {rst, cv, tkl, lck, flt, lat, cmd, msg, tkn} = '0;
    rst = 1'b1;
    rnd(m);
    sn = m[71:0];
    tab = '{default: '0};
    tab[2] = '{16'h0000, 16'h0000, 1'b1, 1'b1, 1'b1};
    tab[5] = '{16'h0083, 16'h0001, 1'b0, 1'b1, 1'b0};
    tab[6] = '{16'h0003, 16'h0001, 1'b0, 1'b0, 1'b0};
    tab[7] = '{16'h0080, 16'h0001, 1'b0, 1'b0, 1'b0};
    tab[8] = '{16'h0083, 16'h0000, 1'b0, 1'b0, 1'b0};
    repeat (12) @(posedge clk);
    chk({rdy, rsp.valid, ctxv}, 3'h4);
    rst <= 1'b0;
    foreach (HC[i]) hash(HC[i][23:16], HC[i][15:0]);
    $display("test hash modes done");
    hash(8'h00, 16'h0000);
    issue(8'h12, 8'h00, 16'h0000, 1'b0);
    repeat (4) @(posedge clk);
    ctx = 0;
    chk(ctxv, 1'b0);
    hash(8'h01, 16'h0040);
    $display("test other opcode done");
    foreach (SC[i]) begin
      @(posedge clk);
      lck <= SC[i][27];
      flt <= SC[i][26];
      ldtk(SC[i][31:28]);
      sign(SC[i][23:16], SC[i][15:0]);
    end
    $display("test signing done");
    tally_and_finish;
  end
endmodule

// ==== tb/hcu_cmd_unit_props.sv ====
`timescale 1ns/1ps
`include "hcu_consts.svh"
// ==========================================================
// Port checks for the command unit
module hcu_cmd_unit_props (
  input wire logic                  i_core_clk,
  input wire logic                  i_rst,
  input wire logic                  i_cmd_valid,
  input wire hcu_pkg::hcu_cmd_t     i_cmd,
  input wire logic                  i_data_locked,
  input wire logic                  o_cmd_ready,
  input wire hcu_pkg::hcu_ecc_req_t o_ecc,
  input wire hcu_pkg::hcu_rsp_t     o_rsp,
  input wire hcu_pkg::hcu_tk_t      o_tk,
  input wire logic                  o_ctx_valid
);
  logic              take;
  logic              hsh;
  logic              err;
  hcu_pkg::hcu_cmd_t lc_r;
  default clocking dc @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  // Answers are judged against the last command taken
  assign take = i_cmd_valid && o_cmd_ready;
  assign hsh = i_cmd.opcode == `HCU_OP_HASH;
  assign err = o_rsp.len == 7'h01 && o_rsp.data[511:504] != 8'h00;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) lc_r <= '0;
    else if (take) lc_r <= i_cmd;
  end
  property p_start;
    take && hsh && i_cmd.mode == 8'h00 && i_cmd.second_parameter != 16'h0000
      |-> ##2 o_rsp.valid && o_rsp.data[511:504] == `HCU_ERR_PARAM;
  endproperty
  a_start: assert property (p_start)
    else $error("start with data not refused");
  property p_end;
    take && hsh && i_cmd.mode inside {8'h02, 8'h05} && i_cmd.second_parameter > 63
      |-> ##2 o_rsp.valid && o_rsp.data[511:504] == `HCU_ERR_PARAM;
  endproperty
  a_end: assert property (p_end)
    else $error("long final block not refused");
  property p_rsvd;
    take && hsh && (i_cmd.mode[7:3] != 5'h00 || i_cmd.mode[2:0] > 3'h5)
      |-> ##2 o_rsp.valid && err;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("bad hash mode not refused");
  property p_dig;
    o_rsp.valid && o_rsp.len == `HCU_DIGEST_BYTES |-> lc_r.opcode ==
      `HCU_OP_HASH && lc_r.mode inside {8'h02, 8'h05} && o_tk.valid &&
      o_tk.data == o_rsp.data[511:256];
  endproperty
  a_dig: assert property (p_dig)
    else $error("digest answer out of place");
  property p_sig;
    o_rsp.valid && lc_r.opcode == `HCU_OP_SIGN
      |-> o_rsp.len == `HCU_SIG_BYTES || err;
  endproperty
  a_sig: assert property (p_sig)
    else $error("sign answer malformed");
  property p_other;
    take && !hsh |=> !o_ctx_valid;
  endproperty
  a_other: assert property (p_other)
    else $error("context kept after other command");
  property p_errclr;
    o_rsp.valid && err |=> !o_ctx_valid && !o_tk.valid;
  endproperty
  a_errclr: assert property (p_errclr)
    else $error("state kept after error");
  property p_slot;
    o_ecc.req |-> o_ecc.slot == lc_r.second_parameter[3:0];
  endproperty
  a_slot: assert property (p_slot)
    else $error("wrong signing slot");
  property p_unlk;
    take && i_cmd.opcode == `HCU_OP_SIGN && !i_cmd.mode[7] && !i_data_locked
      |-> ##[2:40] o_rsp.valid && err;
  endproperty
  a_unlk: assert property (p_unlk)
    else $error("internal sign allowed while unlocked");
  c_sig: cover property (o_rsp.valid && o_rsp.len == `HCU_SIG_BYTES);
  c_dig: cover property (o_rsp.valid && o_rsp.len == `HCU_DIGEST_BYTES);
  c_ecc: cover property (o_ecc.req);
endmodule
bind hcu_cmd_unit hcu_cmd_unit_props i_props (
  .i_core_clk    (i_core_clk),
  .i_rst         (i_rst),
  .i_cmd_valid   (i_cmd_valid),
  .i_cmd         (i_cmd),
  .i_data_locked (i_data_locked),
  .o_cmd_ready   (o_cmd_ready),
  .o_ecc         (o_ecc),
  .o_rsp         (o_rsp),
  .o_tk          (o_tk),
  .o_ctx_valid   (o_ctx_valid)
);

// ==== tb/hcu_far_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// Slot store and engine stand-ins behind the command unit
module hcu_far_model (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  input  wire logic [3:0]            i_slot_sel,
  input  wire hcu_pkg::hcu_slot_t    i_tab [16],
  input  wire hcu_pkg::hcu_sha_req_t i_sha,
  input  wire hcu_pkg::hcu_ecc_req_t i_ecc,
  input  wire logic                  i_fault,
  input  wire logic [3:0]            i_lat,
  output hcu_pkg::hcu_slot_t         o_slot,
  output logic                       o_sha_done,
  output logic [255:0]               o_sha_dig,
  output logic                       o_ecc_done,
  output logic                       o_ecc_fault,
  output logic [511:0]               o_ecc_sig
);
  logic [4:0]   sc;
  logic [4:0]   ec;
  logic [255:0] sd;
  logic [255:0] ed;
  // Settings follow the selected slot in the same cycle
  assign o_slot = i_tab[i_slot_sel];
  // Digest and signature lines carry junk outside the done cycle
  assign o_sha_dig = o_sha_done ? sd : ~sd;
  assign o_ecc_sig = o_ecc_done ? {ed, ~ed} : {~ed, ed};
  assign o_ecc_fault = o_ecc_done & i_fault;
  // Latency counters, zero when idle; the bench varies the latency
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sc <= 5'h00;
      ec <= 5'h00;
      o_sha_done <= 1'b0;
      o_ecc_done <= 1'b0;
    end else begin
      o_sha_done <= 1'b0;
      o_ecc_done <= 1'b0;
      if (i_sha.req) begin
        sc <= {1'b0, i_lat} + 5'h01;
        sd <= i_sha.data[511:256] ^ i_sha.data[255:0];
      end else if (sc == 5'h01) begin
        sc <= 5'h00;
        o_sha_done <= 1'b1;
      end else if (sc != 5'h00) sc <= sc - 5'h01;
      if (i_ecc.req) begin
        ec <= {1'b0, i_lat} + 5'h01;
        ed <= i_ecc.digest;
      end else if (ec == 5'h01) begin
        ec <= 5'h00;
        o_ecc_done <= 1'b1;
      end else if (ec != 5'h00) ec <= ec - 5'h01;
    end
  end
endmodule
